// file: rtl/atc_ctrl.v
// Purpose: Auto-scan threshold-compare control for a SAR converter
// Assumes: Converter core gives a result strobe and a sequence-done strobe
// Notes:   Registers on a plain port; read data one cycle after read strobe
`timescale 1ns/100ps
`default_nettype none
`include "atc_defines.vh"

module atc_ctrl #(
  parameter DW = 12
) (
  input  wire                   clk,          // 10 MHz system clock
  input  wire                   rstn,         // Async reset, active low
  input  wire [`ATC_ADDR_W-1:0] regAddr,      // Register address
  input  wire [15:0]            regWdata,     // Write data
  input  wire                   regWr,        // Write strobe
  input  wire                   regRd,        // Read strobe
  output reg  [15:0]            regRdata,     // Read data, cycle after read
  input  wire                   convValid,    // Conversion result strobe
  input  wire [DW-1:0]          convResult,   // Conversion result
  input  wire                   seqDone,      // Threshold sequence complete
  output reg                    resultWe,     // Store result to buffer
  output reg  [DW-1:0]          resultData,   // Result to store
  output reg                    scanIrq,      // Scan event pulse
  output reg                    bandgapEn,    // Band-gap reference request
  output reg                    chargeUnitEn, // Charge-time unit request
  output reg                    lowPower,     // Low power after scan
  output reg                    irq           // Level interrupt
);

  // ==========================================================
  // Registers
  reg  [15:0]            ctrl_r;
  reg  [`ATC_ST_W-1:0]   stat_r;
  reg  [`ATC_ST_W-1:0]   mask_r;
  reg                    adcOn_r;
  reg                    adcActive_r;
  reg  [DW-1:0]          lo_r;
  reg  [DW-1:0]          hi_r;
  reg                    matchSeen_r;
  reg  [DW-1:0]          lastResult_r;
  reg  [`ATC_ST_W-1:0]   statSet;
  wire                   match;
  wire                   scanEn;
  wire [1:0]             intSel;
  wire [1:0]             wrMode;
  wire                   validMatch;
  reg                    fire;
  reg                    storeNow;

  assign scanEn     = ctrl_r[`ATC_BIT_SCANEN];
  assign intSel     = ctrl_r[`ATC_INT_HI:`ATC_INT_LO];
  assign wrMode     = ctrl_r[`ATC_WRM_HI:`ATC_WRM_LO];
  // Compare only counts while auto-scan is running
  assign validMatch = scanEn && convValid && match;

  atc_compare #(
    .DW(DW)
  ) uCmp (
    .mode   (ctrl_r[`ATC_CMP_HI:`ATC_CMP_LO]),
    .result (convResult),
    .bufLo  (lo_r),
    .bufHi  (hi_r),
    .match  (match)
  );

  // ==========================================================
  // Interrupt and store decisions
  always @*
  begin
    fire = 1'b0;
    case (intSel)
      `ATC_INT_DONE:  fire = scanEn && seqDone;
      `ATC_INT_MATCH: fire = validMatch;
      `ATC_INT_BOTH:  fire = scanEn && seqDone &&
                             (matchSeen_r || validMatch);
      default:        fire = 1'b0;
    endcase
    // Save mode drops scan status unless the result matched, except with interrupt select done
    if ((wrMode == `ATC_WRM_SAVE) && !validMatch && intSel != `ATC_INT_DONE)
      fire = fire && validMatch;
    storeNow = 1'b0;
    case (wrMode)
      `ATC_WRM_LEGACY: storeNow = convValid;
      `ATC_WRM_SAVE:   storeNow = validMatch;
      default:         storeNow = 1'b0;
    endcase
    statSet = {`ATC_ST_W{1'b0}};
    statSet[`ATC_ST_SCANINT] = fire;
    statSet[`ATC_ST_MATCH]   = validMatch;
    statSet[`ATC_ST_DONE]    = scanEn && seqDone;
  end

  // ==========================================================
  // Register writes and block state
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_r       <= `ATC_CTRL_RST;
      mask_r       <= {`ATC_ST_W{1'b0}};
      stat_r       <= {`ATC_ST_W{1'b0}};
      adcOn_r      <= 1'b0;
      adcActive_r  <= 1'b0;
      lo_r         <= {DW{1'b0}};
      hi_r         <= {DW{1'b0}};
      matchSeen_r  <= 1'b0;
      lastResult_r <= {DW{1'b0}};
    end
    else
    begin
      if (regWr)
      begin
        if (regAddr == `ATC_OFS_CTRL)
          ctrl_r <= regWdata & `ATC_CTRL_MASK;
        else if (regAddr == `ATC_OFS_MASK)
          mask_r <= regWdata[`ATC_ST_W-1:0];
        else if (regAddr == `ATC_OFS_RUN)
        begin
          adcActive_r <= regWdata[`ATC_RUN_ACTIVE];
          adcOn_r     <= regWdata[`ATC_RUN_ENABLE];
        end
        else if (regAddr == `ATC_OFS_LO)
          lo_r <= regWdata[DW-1:0];
        else if (regAddr == `ATC_OFS_HI)
          hi_r <= regWdata[DW-1:0];
      end
      // A read clears status, but events of the same cycle stay set
      if (regRd && regAddr == `ATC_OFS_STAT)
        stat_r <= statSet;
      else
        stat_r <= stat_r | statSet;
      if (!scanEn || seqDone)
        matchSeen_r <= 1'b0;
      else if (validMatch)
        matchSeen_r <= 1'b1;
      if (convValid)
        lastResult_r <= convResult;
    end
  end

  // ==========================================================
  // Outputs, all registered
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      regRdata     <= 16'h0000;
      resultWe     <= 1'b0;
      resultData   <= {DW{1'b0}};
      scanIrq      <= 1'b0;
      bandgapEn    <= 1'b0;
      chargeUnitEn <= 1'b0;
      lowPower     <= 1'b0;
      irq          <= 1'b0;
    end
    else
    begin
      regRdata <= 16'h0000;
      if (regRd)
      begin
        if (regAddr == `ATC_OFS_CTRL)
          regRdata <= ctrl_r;
        else if (regAddr == `ATC_OFS_STAT)
          regRdata <= {{(16-`ATC_ST_W){1'b0}}, stat_r};
        else if (regAddr == `ATC_OFS_MASK)
          regRdata <= {{(16-`ATC_ST_W){1'b0}}, mask_r};
        else if (regAddr == `ATC_OFS_RUN)
          regRdata <= {14'h0000, adcOn_r, adcActive_r};
        else if (regAddr == `ATC_OFS_LO)
          regRdata <= {{(16-DW){1'b0}}, lo_r};
        else if (regAddr == `ATC_OFS_HI)
          regRdata <= {{(16-DW){1'b0}}, hi_r};
        else if (regAddr == `ATC_OFS_RESULT)
          regRdata <= {{(16-DW){1'b0}}, lastResult_r};
      end
      resultWe     <= storeNow;
      resultData   <= convResult;
      scanIrq      <= fire;
      bandgapEn    <= ctrl_r[`ATC_BIT_BANDGAP] && adcOn_r && adcActive_r;
      chargeUnitEn <= ctrl_r[`ATC_BIT_CTREQ] && adcOn_r && adcActive_r;
      // Low power holds from a finished scan until scan or low power is switched off
      if (!scanEn || !ctrl_r[`ATC_BIT_LOWPWR])
        lowPower <= 1'b0;
      else if (seqDone)
        lowPower <= 1'b1;
      irq          <= |((stat_r | statSet) & mask_r);
    end
  end

endmodule
`default_nettype wire

// file: rtl/atc_defines.vh
// Purpose: Constants for the auto-scan threshold-compare control block
// Assumes: Plain register port, 16-bit data, one clock
// Notes:   Register offsets are local choices; bit fields follow the control word
//
// Functional notes
// - Interrupt select: none, done, match, both
// - Compare mode: less, greater, inside, outside
// - Write mode: legacy, on match, discard, reserved
// - Band-gap requested only when bit set, active
// - Charge unit requested only when bit set, active
`ifndef ATC_DEFINES_VH
`define ATC_DEFINES_VH

// ==========================================================
// Register map
`define ATC_ADDR_W        4
`define ATC_OFS_CTRL      4'h0
`define ATC_OFS_STAT      4'h1
`define ATC_OFS_MASK      4'h2
`define ATC_OFS_RUN       4'h3
`define ATC_OFS_LO        4'h4
`define ATC_OFS_HI        4'h5
`define ATC_OFS_RESULT    4'h6

// ==========================================================
// Control word fields and reset values
`define ATC_CTRL_RST      16'h0000
`define ATC_CTRL_MASK     16'hF30F
`define ATC_BIT_SCANEN    15
`define ATC_BIT_LOWPWR    14
`define ATC_BIT_CTREQ     13
`define ATC_BIT_BANDGAP   12
`define ATC_INT_HI        9
`define ATC_INT_LO        8
`define ATC_WRM_HI        3
`define ATC_WRM_LO        2
`define ATC_CMP_HI        1
`define ATC_CMP_LO        0

// ==========================================================
// Field encodings
`define ATC_INT_NONE      2'h0
`define ATC_INT_DONE      2'h1
`define ATC_INT_MATCH     2'h2
`define ATC_INT_BOTH      2'h3
`define ATC_WRM_LEGACY    2'h0
`define ATC_WRM_SAVE      2'h1
`define ATC_WRM_CMPONLY   2'h2
`define ATC_WRM_RSVD      2'h3
`define ATC_CMP_LESS      2'h0
`define ATC_CMP_GREATER   2'h1
`define ATC_CMP_INSIDE    2'h2
`define ATC_CMP_OUTSIDE   2'h3

// ==========================================================
// Status bits and run register bits
`define ATC_ST_W          3
`define ATC_ST_SCANINT    0
`define ATC_ST_MATCH      1
`define ATC_ST_DONE       2
`define ATC_RUN_ACTIVE    0
`define ATC_RUN_ENABLE    1

`endif

// file: rtl/atc_compare.v
// Purpose: Valid-match test of a conversion result against a buffer pair
// Assumes: Unsigned results; lo/hi are the buffer pair values
// Notes:   Purely combinational
`timescale 1ns/100ps
`default_nettype none
`include "atc_defines.vh"

module atc_compare #(
  parameter DW = 12
) (
  input  wire [1:0]    mode,      // Compare mode select
  input  wire [DW-1:0] result,    // Conversion result
  input  wire [DW-1:0] bufLo,     // Buffer entry / window low
  input  wire [DW-1:0] bufHi,     // Window high
  output reg           match      // Valid match
);

  always @*
  begin
    case (mode)
      `ATC_CMP_LESS:    match = (result < bufLo);
      `ATC_CMP_GREATER: match = (result > bufLo);
      `ATC_CMP_INSIDE:  match = (result >= bufLo) && (result <= bufHi);
      default:         match = (result < bufLo) || (result > bufHi);
    endcase
  end

endmodule
`default_nettype wire

// file: bench/atc_ctrl_asserts.sv
// Purpose: Port-level assertions for the threshold-compare control
// Assumes: One clock, asynchronous active-low reset
// Notes:   Sees only the top-level ports; bound below
`timescale 1ns/100ps
`default_nettype none
module atc_ctrl_asserts #(
  parameter DW = 12
) (
  input wire logic          clk,          // Clock
  input wire logic          rstn,         // Reset
  input wire logic [3:0]    regAddr,      // Address
  input wire logic [15:0]   regWdata,     // Write data
  input wire logic          regWr,        // Write strobe
  input wire logic          regRd,        // Read strobe
  input wire logic [15:0]   regRdata,     // Read data
  input wire logic          convValid,    // Result strobe
  input wire logic [DW-1:0] convResult,   // Result
  input wire logic          seqDone,      // Sequence done
  input wire logic          resultWe,     // Store
  input wire logic [DW-1:0] resultData,   // Stored value
  input wire logic          scanIrq,      // Scan event
  input wire logic          bandgapEn,    // Band-gap request
  input wire logic          chargeUnitEn, // Charge unit request
  input wire logic          lowPower,     // Low power
  input wire logic          irq           // Interrupt
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // ==========================================
  // Outputs only move for a cause at the inputs
  a_store_cause: assert property (resultWe |-> $past(convValid))
    else $error("store without result");
  a_store_data: assert property (resultWe |-> resultData == $past(convResult))
    else $error("stored value differs");
  a_scan_cause: assert property (scanIrq |-> $past(convValid) || $past(seqDone))
    else $error("scan event without cause");
  a_bg_rise: assert property ($rose(bandgapEn) |-> $past(regWr) || $past(regWr, 2))
    else $error("band-gap rose without write");
  a_cu_rise: assert property ($rose(chargeUnitEn) |-> $past(regWr) || $past(regWr, 2))
    else $error("charge unit rose without write");
  a_lp_rise: assert property ($rose(lowPower) |-> $past(seqDone))
    else $error("low power without scan end");
  a_lp_fall: assert property ($fell(lowPower) |-> $past(regWr) || $past(regWr, 2))
    else $error("low power dropped without write");
endmodule
bind atc_ctrl atc_ctrl_asserts #(.DW(DW)) chk (.clk(clk), .rstn(rstn), .regAddr(regAddr),
  .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
  .convValid(convValid), .convResult(convResult), .seqDone(seqDone), .resultWe(resultWe),
  .resultData(resultData), .scanIrq(scanIrq), .bandgapEn(bandgapEn),
  .chargeUnitEn(chargeUnitEn), .lowPower(lowPower), .irq(irq));
`default_nettype wire

// file: bench/atc_ctrl_tb.sv
// Purpose: Self-checking bench for the threshold-compare control
// Assumes: Register offsets and encodings of the design header
// Notes:   Write mode 11 is never used for conversions, its behaviour is undefined
`timescale 1ns/100ps
`default_nettype none
module atc_ctrl_tb;
  logic        clk;
  logic        rstn = 1'h0;
  logic [3:0]  regAddr = 4'h0;
  logic [15:0] regWdata = 16'h0000;
  logic        regWr = 1'h0;
  logic        regRd = 1'h0;
  logic        convValid = 1'h0;
  logic [11:0] convResult = 12'h000;
  logic        seqDone = 1'h0;
  wire  [15:0] regRdata;
  wire  [11:0] resultData;
  wire         resultWe, scanIrq, bandgapEn, chargeUnitEn, lowPower, irq;
  integer      mismatches = 0;
  integer      numChecks = 0;
`define CHK(n, e, g) begin numChecks++; if ((g) !== (e)) begin mismatches++; \
  $display("wrong value %s expected %0h seen %0h", n, e, g); end end
  atc_ctrl #(.DW(12)) dut (.clk(clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .convValid(convValid),
    .convResult(convResult), .seqDone(seqDone), .resultWe(resultWe), .resultData(resultData),
    .scanIrq(scanIrq), .bandgapEn(bandgapEn), .chargeUnitEn(chargeUnitEn),
    .lowPower(lowPower), .irq(irq));
  // ==========================================
  // Bus and converter drivers
  task wr(input [3:0] a, input [15:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'h1;
    @(posedge clk);
    regWr <= 1'h0;
    // Step off the edge so a following write does not drive the strobe twice at once
    #1;
  endtask
  task rd(input [3:0] a, output [15:0] d);
    regAddr <= a;
    regRd <= 1'h1;
    @(posedge clk);
    regRd <= 1'h0;
    #1 d = regRdata;
  endtask
  // Pulses stand one cycle, so outputs are judged just after the taking edge
  task ev(input v, input s, input [11:0] r, input we, input si);
    convValid <= v;
    seqDone <= s;
    convResult <= r;
    @(posedge clk);
    convValid <= 1'h0;
    seqDone <= 1'h0;
    #1 `CHK("resultWe", we, resultWe)
    `CHK("scanIrq", si, scanIrq)
    if (we) `CHK("resultData", r, resultData)
  endtask
  // ==========================================
  // Scenarios
  task t_regs;
    logic [15:0] d;
    rd(4'h0, d);
    `CHK("ctrl reset", 16'h0000, d)
    wr(4'h0, 16'hFFFF);
    rd(4'h0, d);
    `CHK("ctrl bits", 16'hF30F, d)
    rd(4'h7, d);
    `CHK("unmapped", 16'h0000, d)
    rd(4'h5, d);
    `CHK("window high", 16'h00C8, d)
    $display("test regs done");
  endtask
  task t_cmp;
    // Equal to the low bound separates less, greater and inclusive inside
    for (int m = 0; m < 4; m++)
    begin
      wr(4'h0, 16'h8200 | m[15:0]);
      ev(1'h1, 1'h0, 12'h032, 1'h1, m == 0 || m == 3);
      ev(1'h1, 1'h0, 12'h064, 1'h1, m == 2);
      ev(1'h1, 1'h0, 12'h0C8, 1'h1, m == 1 || m == 2);
    end
    $display("test compare done");
  endtask
  task t_wm;
    for (int m = 0; m < 3; m++)
    begin
      wr(4'h0, 16'h8201 | {m[13:0], 2'h0});
      ev(1'h1, 1'h0, 12'h0C8, m < 2, 1'h1);
      ev(1'h1, 1'h0, 12'h032, m == 0, 1'h0);
    end
    $display("test write mode done");
  endtask
  task t_int;
    logic [15:0] d;
    rd(4'h1, d);
    wr(4'h2, 16'h0001);
    for (int m = 0; m < 4; m++)
    begin
      wr(4'h0, 16'h8001 | {m[7:0], 8'h00});
      ev(1'h1, 1'h0, 12'h0C8, 1'h1, m == 2);
      ev(1'h0, 1'h1, 12'h000, 1'h0, m == 1 || m == 3);
    end
    @(posedge clk);
    #1 `CHK("irq set", 1'h1, irq)
    rd(4'h1, d);
    `CHK("status", 3'h7, d[2:0])
    @(posedge clk);
    #1 `CHK("irq cleared", 1'h0, irq)
    wr(4'h2, 16'h0000);
    ev(1'h0, 1'h1, 12'h000, 1'h0, 1'h0);
    ev(1'h1, 1'h0, 12'h0C8, 1'h1, 1'h0);
    ev(1'h0, 1'h1, 12'h000, 1'h0, 1'h1);
    @(posedge clk);
    #1 `CHK("irq masked", 1'h0, irq)
    rd(4'h6, d);
    `CHK("last result", 16'h00C8, d)
    $display("test interrupt done");
  endtask
  task t_pwr;
    wr(4'h3, 16'h0002);
    wr(4'h0, 16'hF000);
    repeat (2) @(posedge clk);
    #1 `CHK("bandgap idle", 1'h0, bandgapEn)
    wr(4'h3, 16'h0003);
    repeat (2) @(posedge clk);
    #1 `CHK("bandgap", 1'h1, bandgapEn)
    `CHK("charge unit", 1'h1, chargeUnitEn)
    `CHK("full power", 1'h0, lowPower)
    ev(1'h0, 1'h1, 12'h000, 1'h0, 1'h0);
    `CHK("low power", 1'h1, lowPower)
    wr(4'h0, 16'h8000);
    repeat (2) @(posedge clk);
    #1 `CHK("bandgap off", 1'h0, bandgapEn)
    `CHK("charge off", 1'h0, chargeUnitEn)
    `CHK("power back", 1'h0, lowPower)
    $display("test power done");
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", numChecks, mismatches);
    if (mismatches == 0 && numChecks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  // Whole run is under a hundred cycles; allow 5000 cycles
  initial
  begin
    #(5000 * 100);
    mismatches++;
    conclude;
  end
  initial
  begin
    repeat (6) @(posedge clk);
    rstn <= 1'h1;
    @(posedge clk);
    wr(4'h4, 16'h0064);
    wr(4'h5, 16'h00C8);
    t_regs;
    t_cmp;
    t_wm;
    t_int;
    t_pwr;
    conclude;
  end
endmodule
`default_nettype wire
